// File: logic/wsc_pkg.sv
package wsc_pkg;
  localparam int CLK_MHZ = 100;
  // Host-side timing, in the unit printed
  localparam int SAVE_DESELECT_TIME_MS = 20;
  localparam int NOSAVE_DESELECT_TIME_US = 1;
  localparam int STROBE_HIGH_TO_RELEASE_TIME_US = 1;
  localparam int POWERUP_SETTLE_TIME_US = 500;
  localparam int SETUP_TIME_NS = 100;
  localparam int PHASE_TIME_US = 1;
  // Cycle counts derived from the clock rate
  localparam int SAVE_DESELECT_CYC = SAVE_DESELECT_TIME_MS * 1000 * CLK_MHZ;
  localparam int NOSAVE_DESELECT_CYC = NOSAVE_DESELECT_TIME_US * CLK_MHZ;
  localparam int STROBE_HIGH_TO_RELEASE_CYC = STROBE_HIGH_TO_RELEASE_TIME_US * CLK_MHZ;
  localparam int POWERUP_SETTLE_CYC = POWERUP_SETTLE_TIME_US * CLK_MHZ;
  localparam int SETUP_CYC = (SETUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE_CYC = PHASE_TIME_US * CLK_MHZ;
  localparam int TMR_W = 24;
  localparam int POS_W = 7;
  localparam logic [POS_W-1:0] POS_MAX = 7'h63;
  localparam logic [POS_W-1:0] POS_RESET = 7'h00;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h00_0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h00_0001;
endpackage

// File: logic/wsc_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wsc_timer_if;
  import wsc_pkg::*;
  logic load;
  logic [TMR_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// File: logic/wsc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module wsc_timer
  import wsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  wsc_timer_if.tmr tif
);
  typedef struct packed {
    logic [TMR_W-1:0] remain;
  } wsc_tmr_state_type;
  wsc_tmr_state_type st;
  wsc_tmr_state_type next_st;
  always_comb begin
    next_st = st;
    if (tif.load) begin
      next_st.remain = tif.count;
    end else if (st.remain != TMR_ZERO) begin
      next_st.remain = st.remain - TMR_ONE;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Done depends on state only, so the caller may load on done without a loop
  assign tif.done = (st.remain == TMR_ZERO);
endmodule
`default_nettype wire

// File: logic/wsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module wsc_host
  import wsc_pkg::*;
#(
  parameter int SAVE_DESELECT_CYCLES = SAVE_DESELECT_CYC,
  parameter int POWERUP_SETTLE_CYCLES = POWERUP_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic cmdUp,
  input wire logic [POS_W-1:0] cmdSteps,
  input wire logic cmdSave,
  output logic cmdReady,
  output logic selectN,
  output logic strobeN,
  output logic dirUp,
  output logic [POS_W-1:0] trackedPos
);
  typedef enum {ST_POWERUP, ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_END_LOW,
                ST_RELEASE, ST_DESELECT} wsc_state_type;
  typedef struct packed {
    wsc_state_type fsm;
    logic [POS_W-1:0] left;
    logic up;
    logic save;
    logic sel;
    logic stb;
    logic dir;
    logic rdy;
    logic [POS_W-1:0] pos;
    logic puLoaded;
  } wsc_host_state_type;

  wsc_host_state_type st;
  wsc_host_state_type next_st;
  wsc_timer_if tif ();

  wsc_timer u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tif(tif)
  );

  function automatic logic [TMR_W-1:0] cyc(input int n);
    cyc = TMR_W'(n);
  endfunction

  // Host mirror of the device counter
  function automatic logic [POS_W-1:0] step_pos(input logic [POS_W-1:0] p, input logic up);
    if (up) begin
      if (p == POS_MAX) begin
        step_pos = p;
      end else begin
        step_pos = p + 7'h01;
      end
    end else begin
      if (p == POS_RESET) begin
        step_pos = p;
      end else begin
        step_pos = p - 7'h01;
      end
    end
  endfunction

  // Dwell of each timed state, loaded on entry; ST_END_LOW is zero with no load, ST_DESELECT loads deselect_len instead
  function automatic logic [TMR_W-1:0] dwell(input wsc_state_type s);
    case (s)
      ST_POWERUP: begin
        dwell = cyc(POWERUP_SETTLE_CYCLES);
      end
      ST_SETUP: begin
        // Longer of select setup and direction setup
        dwell = cyc(PHASE_CYC > SETUP_CYC ? PHASE_CYC : SETUP_CYC);
      end
      ST_LOW, ST_HIGH: begin
        dwell = cyc(PHASE_CYC);
      end
      ST_RELEASE: begin
        dwell = cyc(STROBE_HIGH_TO_RELEASE_CYC);
      end
      default: begin
        dwell = TMR_ZERO;
      end
    endcase
  endfunction

  // A store keeps the device busy, so select stays high far longer
  function automatic logic [TMR_W-1:0] deselect_len(input logic save);
    if (save) begin
      deselect_len = cyc(SAVE_DESELECT_CYCLES);
    end else begin
      deselect_len = cyc(NOSAVE_DESELECT_CYC);
    end
  endfunction

  always_comb begin
    next_st = st;
    tif.load = 1'b0;
    tif.count = TMR_ZERO;
    case (st.fsm)
      ST_POWERUP: begin
        next_st.puLoaded = 1'b1;
        if (!st.puLoaded) begin
          // First cycle out of reset starts the settle wait
          tif.load = 1'b1;
          tif.count = dwell(ST_POWERUP);
        end else if (tif.done) begin
          next_st.fsm = ST_IDLE;
          next_st.rdy = 1'b1;
        end
      end
      ST_IDLE: begin
        // A zero-step move without store needs no pin activity at all
        if (cmdValid && (cmdSteps != 7'h00 || cmdSave)) begin
          next_st.rdy = 1'b0;
          next_st.up = cmdUp;
          next_st.dir = cmdUp;
          next_st.left = cmdSteps;
          next_st.save = cmdSave;
          next_st.sel = 1'b0;
          next_st.fsm = ST_SETUP;
          tif.load = 1'b1;
          tif.count = dwell(ST_SETUP);
        end
      end
      ST_SETUP, ST_HIGH: begin
        if (tif.done) begin
          if (st.left != 7'h00) begin
            next_st.stb = 1'b0;
            next_st.left = st.left - 7'h01;
            next_st.pos = step_pos(st.pos, st.up);
            next_st.fsm = ST_LOW;
            tif.load = 1'b1;
            tif.count = dwell(ST_LOW);
          end else begin
            // Only a storing move gets here with no steps left
            next_st.fsm = ST_RELEASE;
            tif.load = 1'b1;
            tif.count = dwell(ST_RELEASE);
          end
        end
      end
      ST_LOW: begin
        if (tif.done) begin
          if (st.left == 7'h00 && !st.save) begin
            // Last strobe stays low; strobe high when select rises would store
            next_st.fsm = ST_END_LOW;
          end else begin
            next_st.stb = 1'b1;
            next_st.fsm = ST_HIGH;
            tif.load = 1'b1;
            tif.count = dwell(ST_HIGH);
          end
        end
      end
      ST_END_LOW: begin
        if (tif.done) begin
          next_st.sel = 1'b1;
          next_st.fsm = ST_DESELECT;
          tif.load = 1'b1;
          tif.count = deselect_len(st.save);
        end
      end
      ST_RELEASE: begin
        if (tif.done) begin
          next_st.sel = 1'b1;
          next_st.fsm = ST_DESELECT;
          tif.load = 1'b1;
          tif.count = deselect_len(st.save);
        end
      end
      ST_DESELECT: begin
        // Strobe returns high only with select high, so no step or save
        next_st.stb = 1'b1;
        if (tif.done) begin
          next_st.fsm = ST_IDLE;
          next_st.rdy = 1'b1;
        end
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st.fsm <= ST_POWERUP;
      st.left <= POS_RESET;
      st.up <= 1'b0;
      st.save <= 1'b0;
      st.sel <= 1'b1;
      st.stb <= 1'b1;
      st.dir <= 1'b0;
      st.rdy <= 1'b0;
      st.pos <= POS_RESET;
      st.puLoaded <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cmdReady = st.rdy;
  assign selectN = st.sel;
  assign strobeN = st.stb;
  assign dirUp = st.dir;
  assign trackedPos = st.pos;
endmodule
`default_nettype wire

// File: verif/wsc_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wsc_host_checker
  import wsc_pkg::*;
#(parameter int SAVE_DESELECT_CYCLES = SAVE_DESELECT_CYC) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic selectN,
  input wire logic strobeN
);
  logic [31:0] hiCnt;
  logic [31:0] stCnt;
  logic saved;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hiCnt <= 32'h1000_0000; // First select after reset owes no gap
      stCnt <= 32'h0000_0000;
      saved <= 1'b0;
    end else begin
      hiCnt <= selectN ? hiCnt + 32'h0000_0001 : 32'h0000_0000;
      stCnt <= strobeN ? stCnt + 32'h0000_0001 : 32'h0000_0000;
      saved <= $rose(selectN) ? strobeN : saved;
    end
  end
  property p_save_gap; $fell(selectN) && saved |-> hiCnt >= SAVE_DESELECT_CYCLES - 1; endproperty
  a_save_gap: assert property (p_save_gap) else $error("reselect too soon after store");
  property p_nosave_gap; $fell(selectN) && !saved |-> hiCnt >= NOSAVE_DESELECT_CYC - 1; endproperty
  a_nosave_gap: assert property (p_nosave_gap) else $error("reselect too soon");
  property p_release; $rose(selectN) && strobeN |-> stCnt >= STROBE_HIGH_TO_RELEASE_CYC - 1; endproperty
  a_release: assert property (p_release) else $error("strobe high too short");
  property p_idle; $rose(nrst) |-> selectN && strobeN; endproperty
  a_idle: assert property (p_idle) else $error("pins not idle out of reset");
  property p_nosave_exit; $rose(selectN) && !strobeN |-> ##[1:101] strobeN; endproperty
  a_nosave_exit: assert property (p_nosave_exit) else $error("strobe stuck low");
  property p_strobe_sel; $fell(strobeN) |-> !selectN; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe while deselected");
endmodule
bind wsc_host wsc_host_checker #(.SAVE_DESELECT_CYCLES(SAVE_DESELECT_CYCLES)) u_wsc_host_checker (
  .sys_clk(sys_clk), .nrst(nrst), .selectN(selectN), .strobeN(strobeN));
`default_nettype wire

// File: verif/wsc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module wsc_dev_model
  import wsc_pkg::*;
#(parameter int SAVE_NS = 1500) (
  input wire logic selectN,
  input wire logic strobeN,
  input wire logic dirUp,
  output logic [POS_W-1:0] tap,
  output logic [POS_W-1:0] nvStore,
  output logic [7:0] saves
);
  logic saving = 1'b0;
  logic armed = 1'b0;
  initial begin
    nvStore = 7'h00;
    tap = nvStore; // Recalled and settled at once
    saves = 8'h00;
  end
  always @(negedge selectN) armed = 1'b1;
  always @(negedge strobeN) begin
    if (selectN === 1'b0 && !saving) begin
      if (dirUp) tap = (tap == POS_MAX) ? tap : tap + 7'h01;
      else tap = (tap == 7'h00) ? tap : tap - 7'h01;
    end
  end
  always @(posedge selectN) begin
    if (armed && strobeN === 1'b1) begin // Strobe low skips the store
      nvStore = tap;
      saves = saves + 8'h01;
      saving = 1'b1;
      #SAVE_NS saving = 1'b0; // Busy for SAVE_NS, strobes ignored meanwhile
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wsc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdUp = 1'b0;
  logic [POS_W-1:0] cmdSteps = 7'h00;
  logic cmdSave = 1'b0;
  logic cmdReady, selectN, strobeN, dirUp;
  logic [POS_W-1:0] trackedPos, tap, nvStore;
  logic [7:0] saves;
  int n_errors = 0;
  int total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  localparam int PU_CYC = 300;
  wsc_host #(.SAVE_DESELECT_CYCLES(200), .POWERUP_SETTLE_CYCLES(PU_CYC)) u_wsc_host (.sys_clk,
    .nrst, .cmdValid, .cmdUp,
    .cmdSteps, .cmdSave, .cmdReady, .selectN, .strobeN, .dirUp, .trackedPos);
  wsc_dev_model u_wsc_dev_model (.selectN, .strobeN, .dirUp, .tap, .nvStore, .saves);
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 30000 && cmdReady !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (cmdReady !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic send(input logic up, input logic [POS_W-1:0] n, input logic sv);
    wait_ready();
    cmdValid = 1'b1;
    cmdUp = up;
    cmdSteps = n;
    cmdSave = sv;
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    @(posedge sys_clk);
    #1;
    wait_ready();
  endtask
  task automatic t_powerup();
    int n = 0;
    while (cmdReady !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    wait_ready();
    chk(8'(n >= PU_CYC), 8'h01);
  endtask
  task automatic t_up_sat();
    send(1'b1, 7'h64, 1'b0);
    chk({1'b0, tap}, 8'h63);
    chk({1'b0, trackedPos}, 8'h63);
    chk(saves, 8'h00);
  endtask
  task automatic t_save_then_move();
    send(1'b0, 7'h03, 1'b1);
    chk({1'b0, nvStore}, 8'h60);
    send(1'b1, 7'h01, 1'b0);
    chk({1'b0, tap}, 8'h61);
    chk(saves, 8'h01);
  endtask
  task automatic t_zero_save();
    send(1'b0, 7'h00, 1'b1);
    chk({1'b0, nvStore}, 8'h61);
    chk(saves, 8'h02);
  endtask
  task automatic t_down_sat();
    send(1'b0, 7'h7f, 1'b0);
    chk({1'b0, tap}, 8'h00);
    chk({1'b0, trackedPos}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    chk({6'h00, selectN, strobeN}, 8'h03);
    nrst = 1'b1;
    chk({1'b0, tap}, 8'h00);
    t_powerup();
    t_up_sat();
    t_save_then_move();
    t_zero_save();
    t_down_sat();
    print_verdict();
  end
endmodule
`default_nettype wire
